// ==== buffered_capture_pulse_accum.sv ====
/*
 Capture timer core: 16-bit main timer, eight capture channels, four
 with holding registers, four pulse accumulators and a modulus counter.
 Assumes an APB master on clk and asynchronous capture pins.
*/
`timescale 1ns/1ns
// Behaviour
// - Eight channels, each selectable as capture or compare.
// - A valid pin edge stores the main timer in the capture register.
// - Channels 0..3 add a holding register; 4..7 have capture only.
// - Capture register is empty after a read or a move to holding.
// - Holding register is empty after a read.
// - Unbuffered: overwrite unless no-overwrite set and register full.
// - Latch mode copies captures to holding on zero, zero write, force.
// - Latch mode without protection overwrites capture and holding.
// - With protection, buffered registers only written when empty.
// - Queue mode shifts old capture to holding, then stores new value.
// - Queue mode holding read moves accumulator to its holding, clears it.
// - Four 8-bit edge accumulators with 8-bit holding registers.
// - With saturation set unpaired accumulators stop at 255, paired ones at 65535.
// - Each accumulator pair may act as one 16-bit accumulator.
// - Accumulator latch mode copies and clears on the three latch events.
// - 16-bit modulus down-counter behind a 4-bit prescaler.
// - Modulus counter is a periodic or one-shot time base flagging each zero.
// - Modulus latching is periodic or only once.
// - Main timer runs behind a 7-bit prescaler.
// - Selectable delay filter on the capture inputs.
// - Main timer is a 16-bit up counter.
// - Select bit zero means capture, one means compare.
module buffered_capture_pulse_accum
    import ect_pkg::*;
(
    input wire logic clk,
    input wire logic nrst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [NCHAN-1:0] capturePins,
    output logic modulusZero
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    function automatic logic hitReg(input logic [7:0] a, input logic [7:0] off);
        return a[7:2] == off[7:2];
    endfunction : hitReg

    logic [NCHAN-1:0] chanFunctionSelect_reg;
    logic [NCHAN-1:0] noOverwriteEnable_reg;
    logic [SYS_W-1:0] captureSystemCtrl_reg;
    logic [2*NCHAN-1:0] edgeSel_reg;
    logic [7:0] modulusCtrl_reg;
    logic [TW-1:0] modLoad_reg;
    logic [TW-1:0] modCount_reg;
    logic [3:0] modPre_reg;
    logic modZeroFlag_reg;
    logic [6:0] mainPre_reg;
    logic [TW-1:0] timer_reg;
    logic [TW-1:0] cap_reg [NCHAN];
    logic [NCHAN-1:0] capEmpty_reg;
    logic [TW-1:0] hold_reg [NBUF];
    logic [NBUF-1:0] holdEmpty_reg;
    logic [7:0] acc_reg [NBUF];
    logic [7:0] accHold_reg [NBUF];
    logic [31:0] prdata_reg;
    logic pready_reg;
    logic pslverr_reg;
    logic modulusZero_reg;
    logic [31:0] readData;
    logic [NCHAN-1:0] doCap;
    logic [NCHAN-1:0] doShift;
    logic [NCHAN-1:0] capEmptyEff;
    logic [NBUF-1:0] inc;
    logic [NBUF-1:0] xfer;
    logic [NBUF/2-1:0] carry;

    edge_if ef();

    edge_filter u_edge (
        .clk(clk),
        .nrst(nrst),
        .pins(capturePins),
        .ef(ef.detector)
    );

    // Field views of the control registers
    wire latchMode = captureSystemCtrl_reg[LATCH_OR_QUEUE_SEL_BIT];
    wire accumSaturateEnable = captureSystemCtrl_reg[SAT_BIT];
    wire [1:0] paired = captureSystemCtrl_reg[PAIR_LSB +: 2];
    wire timerEn = captureSystemCtrl_reg[TIMER_EN_BIT];
    wire [2:0] preSel = captureSystemCtrl_reg[PRE_LSB +: 3];
    wire modEn = modulusCtrl_reg[MOD_EN_BIT];
    wire modPeriodic = modulusCtrl_reg[MOD_PERIODIC_BIT];
    wire [3:0] modPreSel = modulusCtrl_reg[MOD_PRE_LSB +: 4];
    assign ef.filterSel = captureSystemCtrl_reg[FILT_LSB +: 2];
    assign ef.edgeSel = edgeSel_reg;

    // APB phases; reads act one edge before completion so data never goes stale
    wire access = psel & penable;
    wire rdTake = access & ~pready_reg & ~pwrite;
    wire wrDone = access & pready_reg & pwrite;
    wire inCap = paddr[7:5] == OFF_CAP_BASE[7:5];
    wire inHold = paddr[7:4] == OFF_HOLD_BASE[7:4];
    // Index compared one bit wider so a full set of four stays reachable
    wire inAcc = (paddr[7:4] == OFF_ACC_BASE[7:4]) && ({1'b0, paddr[3:2]} < 3'(NBUF));
    wire inAccH = (paddr[7:4] == OFF_ACCH_BASE[7:4]) && ({1'b0, paddr[3:2]} < 3'(NBUF));
    wire [2:0] capSel = paddr[4:2];
    wire [1:0] bufSel = paddr[3:2];
    wire mapped = hitReg(paddr, OFF_CHAN_FN) | hitReg(paddr, OFF_NO_OVW) | hitReg(paddr, OFF_CAP_SYS)
        | hitReg(paddr, OFF_EDGE) | hitReg(paddr, OFF_MOD_CTRL) | hitReg(paddr, OFF_MOD_CNT)
        | hitReg(paddr, OFF_TIMER) | hitReg(paddr, OFF_MOD_STAT) | inCap | inHold | inAcc | inAccH;

    // Write strobes, one per register
    wire wrChanFn = wrDone & hitReg(paddr, OFF_CHAN_FN);
    wire wrNoOvw = wrDone & hitReg(paddr, OFF_NO_OVW);
    wire wrSys = wrDone & hitReg(paddr, OFF_CAP_SYS);
    wire wrEdge = wrDone & hitReg(paddr, OFF_EDGE);
    wire wrModCtrl = wrDone & hitReg(paddr, OFF_MOD_CTRL);
    wire wrModCnt = wrDone & hitReg(paddr, OFF_MOD_CNT);
    wire wrModStat = wrDone & hitReg(paddr, OFF_MOD_STAT);
    wire forceLatch = wrModCtrl & pwdata[FORCE_LATCH_BIT];
    wire wrZero = wrModCnt & (pwdata[TW-1:0] == TW_ZERO);

    // Read side effects, one per channel
    wire [NCHAN-1:0] rdCap = {NCHAN{rdTake & inCap}} & (NCHAN'(1) << capSel);
    wire [NBUF-1:0] rdHold = {NBUF{rdTake & inHold}} & (NBUF'(1) << bufSel);

    // Register read selection
    always_comb begin
        readData = 32'h0000_0000;
        if (hitReg(paddr, OFF_CHAN_FN)) readData[NCHAN-1:0] = chanFunctionSelect_reg;
        else if (hitReg(paddr, OFF_NO_OVW)) readData[NCHAN-1:0] = noOverwriteEnable_reg;
        else if (hitReg(paddr, OFF_CAP_SYS)) readData[SYS_W-1:0] = captureSystemCtrl_reg;
        else if (hitReg(paddr, OFF_EDGE)) readData[2*NCHAN-1:0] = edgeSel_reg;
        else if (hitReg(paddr, OFF_MOD_CTRL)) readData[7:0] = modulusCtrl_reg;
        else if (hitReg(paddr, OFF_MOD_CNT)) readData[TW-1:0] = modCount_reg;
        else if (hitReg(paddr, OFF_TIMER)) readData[TW-1:0] = timer_reg;
        else if (hitReg(paddr, OFF_MOD_STAT)) readData[0] = modZeroFlag_reg;
        else if (inCap) readData[TW-1:0] = cap_reg[capSel];
        else if (inHold) readData[TW-1:0] = hold_reg[bufSel];
        else if (inAcc) readData[7:0] = acc_reg[bufSel];
        else if (inAccH) readData[7:0] = accHold_reg[bufSel];
    end

    // Bus answer: one wait state, registered outputs
    always_ff @(posedge clk) begin
        if (!nrst) begin
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
            prdata_reg <= 32'h0000_0000;
        end else begin
            pready_reg <= access & ~pready_reg;
            if (access & ~pready_reg) begin
                prdata_reg <= pwrite ? 32'h0000_0000 : readData;
                pslverr_reg <= ~mapped;
            end
        end
    end

    // Software control registers; force-latch bit is a pulse and not kept
    always_ff @(posedge clk) begin
        if (!nrst) begin
            chanFunctionSelect_reg <= CHAN_FN_RST;
            noOverwriteEnable_reg <= NO_OVW_RST;
            captureSystemCtrl_reg <= SYS_RST;
            edgeSel_reg <= EDGE_RST;
            modulusCtrl_reg <= MOD_CTRL_RST;
        end else begin
            if (wrChanFn) chanFunctionSelect_reg <= pwdata[NCHAN-1:0];
            if (wrNoOvw) noOverwriteEnable_reg <= pwdata[NCHAN-1:0];
            if (wrSys) captureSystemCtrl_reg <= pwdata[SYS_W-1:0];
            if (wrEdge) edgeSel_reg <= pwdata[2*NCHAN-1:0];
            if (wrModCtrl) modulusCtrl_reg <= pwdata[7:0] & ~(8'h01 << FORCE_LATCH_BIT);
        end
    end

    // Main timer behind a power-of-two prescaler
    wire [6:0] preMask = ~(7'h7F << preSel);
    wire timerTick = timerEn & ((mainPre_reg & preMask) == preMask);
    always_ff @(posedge clk) begin
        if (!nrst) begin
            mainPre_reg <= 7'h00;
            timer_reg <= TW_ZERO;
        end else begin
            mainPre_reg <= timerEn ? mainPre_reg + 7'h01 : 7'h00;
            if (timerTick) timer_reg <= timer_reg + MOD_ONE;
        end
    end

    timer_up_a: assert property (timerTick |=> timer_reg == $past(timer_reg) + MOD_ONE)
        else $error("main timer did not advance by one");

    // Modulus counter: divide by prescale+1, stop or reload at zero
    wire modTick = modEn & (modPre_reg == modPreSel);
    wire modZeroEv = modTick & (modCount_reg == MOD_ONE);
    wire latchEv = modZeroEv | wrZero | forceLatch;
    wire [TW-1:0] modCountNext = wrModCnt ? pwdata[TW-1:0]
        : !modTick ? modCount_reg
        : (modCount_reg <= MOD_ONE) ? (modPeriodic ? modLoad_reg : TW_ZERO)
        : modCount_reg - MOD_ONE;
    always_ff @(posedge clk) begin
        if (!nrst) begin
            modPre_reg <= 4'h0;
            modCount_reg <= TW_ZERO;
            modLoad_reg <= TW_ZERO;
            modZeroFlag_reg <= 1'b0;
            modulusZero_reg <= 1'b0;
        end else begin
            modPre_reg <= (!modEn || modTick) ? 4'h0 : modPre_reg + 4'h1;
            modCount_reg <= modCountNext;
            if (wrModCnt) modLoad_reg <= pwdata[TW-1:0];
            // Set wins over a write-one clear
            modZeroFlag_reg <= modZeroEv | (modZeroFlag_reg & ~(wrModStat & pwdata[0]));
            modulusZero_reg <= modZeroEv;
        end
    end

    sequence zeroSeen;
        modZeroEv && !wrModCnt;
    endsequence
    sequence zeroMarked;
        modulusZero_reg && modZeroFlag_reg;
    endsequence
    mod_zero_a: assert property (zeroSeen |=> zeroMarked)
        else $error("modulus zero not flagged");
    mod_reload_a: assert property (zeroSeen ##0 modPeriodic |=> modCount_reg == $past(modLoad_reg))
        else $error("periodic modulus did not reload");
    // One-shot mode must rest at zero so no second latch follows
    oneshot_stop_a: assert property (zeroSeen ##0 !modPeriodic |=> modCount_reg == TW_ZERO)
        else $error("one-shot modulus did not stop at zero");
    zero_write_a: assert property (wrZero && latchMode
        |=> modCount_reg == TW_ZERO && accHold_reg[0] == $past(acc_reg[0]))
        else $error("zero write did not latch");

    // Capture channels; compare-selected channels ignore their pin
    wire [NCHAN-1:0] capEv = ef.edgePulse & ~chanFunctionSelect_reg;
    for (genvar i = 0; i < NCHAN; i++) begin : g_cap
        assign capEmptyEff[i] = capEmpty_reg[i] | rdCap[i];
        assign doCap[i] = capEv[i] & (~noOverwriteEnable_reg[i] | capEmptyEff[i] | doShift[i]);
        always_ff @(posedge clk) begin
            if (!nrst) begin
                cap_reg[i] <= TW_ZERO;
                capEmpty_reg[i] <= 1'b1;
            end else begin
                if (doCap[i]) cap_reg[i] <= timer_reg;
                capEmpty_reg[i] <= ~doCap[i] & (capEmptyEff[i] | doShift[i]);
            end
        end
        cap_store_a: assert property (doCap[i] |=> cap_reg[i] == $past(timer_reg))
            else $error("capture did not store the timer");
        cap_read_a: assert property (rdCap[i] && !doCap[i] |=> capEmpty_reg[i])
            else $error("capture not empty after read");
        // A read racing a capture must not lose the new value
        cap_race_a: assert property (rdCap[i] && capEv[i] |=> !capEmpty_reg[i] && cap_reg[i] == $past(timer_reg))
            else $error("capture lost against a read");
        if (i < NBUF) begin : g_buf
            // Latch mode moves on latch events, queue mode on captures
            wire holdEmptyEff = holdEmpty_reg[i] | rdHold[i];
            wire shiftTrig = latchMode ? latchEv : capEv[i];
            assign doShift[i] = shiftTrig & ~capEmptyEff[i] & (~noOverwriteEnable_reg[i] | holdEmptyEff);
            always_ff @(posedge clk) begin
                if (!nrst) begin
                    hold_reg[i] <= TW_ZERO;
                    holdEmpty_reg[i] <= 1'b1;
                end else begin
                    if (doShift[i]) hold_reg[i] <= cap_reg[i];
                    holdEmpty_reg[i] <= ~doShift[i] & holdEmptyEff;
                end
            end
            sequence queueShift;
                !latchMode && capEv[i] && !noOverwriteEnable_reg[i] && !capEmptyEff[i];
            endsequence
            queue_shift_a: assert property (queueShift |=> hold_reg[i] == $past(cap_reg[i])
                && cap_reg[i] == $past(timer_reg))
                else $error("queue mode did not shift capture");
            latch_copy_a: assert property (latchMode && latchEv && !noOverwriteEnable_reg[i] && !capEmptyEff[i]
                |=> hold_reg[i] == $past(cap_reg[i]))
                else $error("latch event did not copy capture");
            hold_guard_a: assert property (noOverwriteEnable_reg[i] && !holdEmpty_reg[i] && !rdHold[i]
                |=> $stable(hold_reg[i]))
                else $error("protected holding register overwritten");
        end else begin : g_plain
            assign doShift[i] = 1'b0;
            plain_guard_a: assert property (noOverwriteEnable_reg[i] && !capEmptyEff[i]
                |=> $stable(cap_reg[i]))
                else $error("protected capture overwritten");
        end
    end

    // Pulse accumulators; pairs are low even, high odd
    for (genvar i = 0; i < NBUF; i++) begin : g_acc
        localparam int P = i / 2;
        localparam int PARTNER = i ^ 1;
        wire accFull = acc_reg[i] == ACC_MAX;
        if ((i % 2) == 0) begin : g_lo
            // Paired low half saturates only when the whole pair is full
            assign inc[i] = capEv[i] & ~(accumSaturateEnable & accFull
                & (~paired[P] | (acc_reg[PARTNER] == ACC_MAX)));
            assign carry[P] = inc[i] & accFull;
            acc_count_a: assert property (capEv[i] && !accFull && !xfer[i]
                |=> acc_reg[i] == $past(acc_reg[i]) + 8'h01)
                else $error("accumulator missed an edge");
        end else begin : g_hi
            assign inc[i] = paired[P] ? carry[P] : capEv[i] & ~(accumSaturateEnable & accFull);
            pair_carry_a: assert property (paired[P] && carry[P] && !xfer[i]
                |=> acc_reg[i] == $past(acc_reg[i]) + 8'h01)
                else $error("paired carry not counted");
        end
        assign xfer[i] = latchMode ? latchEv : (rdHold[i] | (paired[P] & rdHold[PARTNER]));
        always_ff @(posedge clk) begin
            if (!nrst) begin
                acc_reg[i] <= 8'h00;
                accHold_reg[i] <= 8'h00;
            end else begin
                // An edge arriving with the transfer is counted, not lost
                acc_reg[i] <= xfer[i] ? {7'h00, inc[i]} : acc_reg[i] + {7'h00, inc[i]};
                if (xfer[i]) accHold_reg[i] <= acc_reg[i];
            end
        end
        acc_xfer_a: assert property (xfer[i] |=> accHold_reg[i] == $past(acc_reg[i]) && acc_reg[i] <= 8'h01)
            else $error("accumulator transfer or clear failed");
        acc_sat_a: assert property (accumSaturateEnable && accFull && !xfer[i] && !paired[P]
            |=> acc_reg[i] == ACC_MAX)
            else $error("saturated accumulator moved");
    end

    bus_wait_a: assert property (access && !pready_reg |=> pready_reg ##1 !pready_reg)
        else $error("bus answer timing broken");
    // Unmapped words answer with an error in the same wait state
    bad_addr_a: assert property (access && !pready_reg && !mapped |=> pready_reg && pslverr_reg)
        else $error("unmapped word not flagged");

    assign prdata = prdata_reg;
    assign pready = pready_reg;
    assign pslverr = pslverr_reg;
    assign modulusZero = modulusZero_reg;
endmodule : buffered_capture_pulse_accum

// ==== buffered_capture_pulse_accum_test.sv ====
/*
 Self-checking bench for the capture timer: APB register traffic and pin edges.
 Assumes one wait state APB slave and the register map of the core package.
*/
`timescale 1ns/1ns
module buffered_capture_pulse_accum_test;
    import ect_pkg::*;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic modulusZero;
    logic [NCHAN-1:0] capturePins;
    logic [31:0] rd;
    logic [31:0] a;
    logic [31:0] b;
    logic err;
    int badCount = 0;
    int checks = 0;
    int n;
    // Address, value after reset, error flag
    logic [40:0] rows [13] = '{{8'h00, 32'h0, 1'b0}, {8'h04, 32'h0, 1'b0}, {8'h08, 32'h0, 1'b0},
        {8'h0C, 32'h0, 1'b0}, {8'h10, 32'h0, 1'b0}, {8'h14, 32'h0, 1'b0}, {8'h18, 32'h0, 1'b0},
        {8'h1C, 32'h0, 1'b0}, {8'h20, 32'h0, 1'b0}, {8'h40, 32'h0, 1'b0}, {8'h50, 32'h0, 1'b0},
        {8'h60, 32'h0, 1'b0}, {8'hFC, 32'h0, 1'b1}};

    always #5 clk = ~clk;

    buffered_capture_pulse_accum u_dut (.clk(clk), .nrst(nrst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .capturePins(capturePins), .modulusZero(modulusZero));

    capture_pin_driver u_pins (.clk(clk), .pins(capturePins));

    task automatic end_sim();
        if (badCount == 0 && checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : end_sim

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            badCount++;
            $display("[ERR] %0t saw %h expected %h", $time, seen, exp);
        end
    endtask : chk

    // One APB transfer; request held until pready is sampled high
    task automatic apb(input logic wr, input logic [7:0] ad, input logic [31:0] wd,
        output logic [31:0] rdv, output logic er);
        int k;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= ad;
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'b1;
        k = 0;
        // Poll between edges so the answer is read settled, not in its launch step
        do begin
            @(negedge clk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        @(posedge clk);
        rdv = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (k >= 20) begin
            badCount++;
            end_sim();
        end
    endtask : apb

    initial begin
        repeat (2) @(posedge clk);
        nrst <= 1'b1;
        chk(32'(modulusZero), 32'h0);
        // Reset values and the unmapped word
        for (int i = 0; i < 13; i++) begin
            apb(1'b0, rows[i][40:33], 32'h0, rd, err);
            chk(rd, rows[i][32:1]);
            chk(32'(err), 32'(rows[i][0]));
        end
        // Queue mode, timer on, rising edges on every channel
        apb(1'b1, OFF_CAP_SYS, 32'h40, rd, err);
        apb(1'b1, OFF_EDGE, 32'h5555, rd, err);
        apb(1'b0, OFF_TIMER, 32'h0, a, err);
        apb(1'b0, OFF_TIMER, 32'h0, b, err);
        chk(32'(b > a), 32'h1);
        // Channel 4 protected, channel 5 not: two captures each
        apb(1'b1, OFF_NO_OVW, 32'h10, rd, err);
        u_pins.pulse(8'h30);
        u_pins.pulse(8'h30);
        apb(1'b0, 8'h30, 32'h0, a, err);
        apb(1'b0, 8'h34, 32'h0, b, err);
        chk(32'(a != 0 && a < b), 32'h1);
        // A compare channel never captures
        apb(1'b1, OFF_CHAN_FN, 32'h40, rd, err);
        u_pins.pulse(8'h40);
        apb(1'b0, 8'h38, 32'h0, rd, err);
        chk(rd, 32'h0);
        // Queue shift, then holding read moves the accumulator
        u_pins.pulse(8'h01);
        u_pins.pulse(8'h01);
        apb(1'b0, OFF_HOLD_BASE, 32'h0, a, err);
        apb(1'b0, OFF_CAP_BASE, 32'h0, b, err);
        chk(32'(a != 0 && a < b), 32'h1);
        apb(1'b0, OFF_ACCH_BASE, 32'h0, rd, err);
        chk(rd, 32'h2);
        apb(1'b0, OFF_ACC_BASE, 32'h0, rd, err);
        chk(rd, 32'h0);
        // Protected queue channel 3 beside plain channel 5; pulses are 13 cycles apart
        apb(1'b1, OFF_NO_OVW, 32'h18, rd, err);
        for (int i = 0; i < 3; i++)
            u_pins.pulse(8'h28);
        apb(1'b0, 8'h4C, 32'h0, a, err);
        apb(1'b0, 8'h2C, 32'h0, b, err);
        apb(1'b0, 8'h34, 32'h0, rd, err);
        chk(b - a, 32'h0000_000D);
        chk(rd - b, 32'h0000_000D);
        // Latch mode, saturation, pair 0/1; channels 0 and 2 get more than 255 edges
        apb(1'b1, OFF_CAP_SYS, 32'h47, rd, err);
        for (int i = 0; i < 260; i++)
            u_pins.pulse(i < 3 ? 8'h07 : 8'h05);
        apb(1'b1, OFF_MOD_CTRL, 32'h4, rd, err);
        apb(1'b0, 8'h44, 32'h0, rd, err);
        chk(32'(rd != 0), 32'h1);
        apb(1'b0, 8'h64, 32'h0, rd, err);
        chk(rd, 32'h1);
        apb(1'b0, OFF_ACCH_BASE, 32'h0, rd, err);
        chk(rd, 32'h4);
        apb(1'b0, 8'h54, 32'h0, rd, err);
        chk(rd, 32'h0);
        apb(1'b0, 8'h68, 32'h0, rd, err);
        chk(rd, 32'(ACC_MAX));
        // Periodic modulus counter: zero pulse and status flag
        apb(1'b1, OFF_MOD_CNT, 32'h3, rd, err);
        apb(1'b1, OFF_MOD_CTRL, 32'h3, rd, err);
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while (modulusZero !== 1'b1 && n < 100);
        chk(32'(n < 100), 32'h1);
        apb(1'b0, OFF_MOD_STAT, 32'h0, rd, err);
        chk(rd & 32'h1, 32'h1);
        // One-shot modulus: one zero pulse, then the count rests at zero
        apb(1'b1, OFF_MOD_CTRL, 32'h1, rd, err);
        apb(1'b1, OFF_MOD_CNT, 32'h3, rd, err);
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while (modulusZero !== 1'b1 && n < 100);
        chk(32'(n < 100), 32'h1);
        n = 0;
        repeat (30) begin
            @(negedge clk);
            if (modulusZero === 1'b1) n++;
        end
        chk(32'(n), 32'h0);
        apb(1'b0, OFF_MOD_CNT, 32'h0, rd, err);
        chk(rd, 32'h0);
        // Mid-run reset clears controls, holding registers and the zero flag
        @(posedge clk);
        nrst <= 1'b0;
        repeat (2) @(posedge clk);
        nrst <= 1'b1;
        chk(32'(modulusZero), 32'h0);
        apb(1'b0, OFF_CAP_SYS, 32'h0, rd, err);
        chk(rd, 32'(SYS_RST));
        apb(1'b0, 8'h44, 32'h0, rd, err);
        chk(rd, 32'(TW_ZERO));
        apb(1'b0, OFF_MOD_STAT, 32'h0, rd, err);
        chk(rd, 32'h0);
        end_sim();
    end
endmodule : buffered_capture_pulse_accum_test

// ==== capture_pin_driver.sv ====
/*
 Far-side model of the capture input pins: drives clean level pulses.
 Assumes the core samples the pins on the same rising clock edge.
*/
`timescale 1ns/1ns
module capture_pin_driver
    import ect_pkg::*;
(
    input wire logic clk,
    output logic [NCHAN-1:0] pins
);
    initial begin
        pins = 8'h00;
    end

    // One rising then one falling edge on every pin in the mask
    // Six cycles per level clears the synchroniser and zero filter delay
    task automatic pulse(input logic [NCHAN-1:0] mask);
        @(posedge clk);
        pins <= pins | mask;
        repeat (6) @(posedge clk);
        pins <= pins & ~mask;
        repeat (6) @(posedge clk);
    endtask : pulse
endmodule : capture_pin_driver

// ==== ect_pkg.sv ====
/*
 Constants for the buffered capture timer: register offsets, field
 positions, reset values and input filter delays.
 Assumes a 32-bit APB slave decoding an 8-bit, word-aligned byte address.
*/
package ect_pkg;
    localparam int NCHAN = 8;
    localparam int NBUF = 4;
    localparam int TW = 16;
    // Register byte offsets
    localparam logic [7:0] OFF_CHAN_FN = 8'h00;
    localparam logic [7:0] OFF_NO_OVW = 8'h04;
    localparam logic [7:0] OFF_CAP_SYS = 8'h08;
    localparam logic [7:0] OFF_EDGE = 8'h0C;
    localparam logic [7:0] OFF_MOD_CTRL = 8'h10;
    localparam logic [7:0] OFF_MOD_CNT = 8'h14;
    localparam logic [7:0] OFF_TIMER = 8'h18;
    localparam logic [7:0] OFF_MOD_STAT = 8'h1C;
    localparam logic [7:0] OFF_CAP_BASE = 8'h20;
    localparam logic [7:0] OFF_HOLD_BASE = 8'h40;
    localparam logic [7:0] OFF_ACC_BASE = 8'h50;
    localparam logic [7:0] OFF_ACCH_BASE = 8'h60;
    // Capture system control fields
    localparam int LATCH_OR_QUEUE_SEL_BIT = 0;
    localparam int SAT_BIT = 1;
    localparam int PAIR_LSB = 2;
    localparam int FILT_LSB = 4;
    localparam int TIMER_EN_BIT = 6;
    localparam int PRE_LSB = 8;
    localparam int SYS_W = 11;
    // Modulus control fields
    localparam int MOD_EN_BIT = 0;
    localparam int MOD_PERIODIC_BIT = 1;
    localparam int FORCE_LATCH_BIT = 2;
    localparam int MOD_PRE_LSB = 4;
    // Values after reset, counter step and accumulator maximum
    localparam logic [7:0] CHAN_FN_RST = 8'h00;
    localparam logic [7:0] NO_OVW_RST = 8'h00;
    localparam logic [SYS_W-1:0] SYS_RST = 11'h000;
    localparam logic [15:0] EDGE_RST = 16'h0000;
    localparam logic [7:0] MOD_CTRL_RST = 8'h00;
    localparam logic [TW-1:0] TW_ZERO = 16'h0000;
    localparam logic [TW-1:0] MOD_ONE = 16'h0001;
    localparam logic [7:0] ACC_MAX = 8'hFF;
    // Input filter delay in cycles for each filter selection
    localparam logic [7:0] FILTER_CYCLES [4] = '{8'h00, 8'h04, 8'h10, 8'h40};
endpackage : ect_pkg

// ==== edge_filter.sv ====
/*
 Input edge detector: two-stage synchroniser, stability delay filter and
 per-channel edge selection, one pulse per accepted edge.
 Assumes raw pins are asynchronous to clk.
*/
`timescale 1ns/1ns
module edge_filter
    import ect_pkg::*;
(
    input wire logic clk,
    input wire logic nrst,
    input wire logic [NCHAN-1:0] pins,
    edge_if.detector ef
);
    logic [NCHAN-1:0] sync1_reg;
    logic [NCHAN-1:0] sync2_reg;
    logic [NCHAN-1:0] filt_reg;
    logic [NCHAN-1:0] pulse_reg;
    logic [7:0] cnt_reg [NCHAN];
    wire [7:0] limit = FILTER_CYCLES[ef.filterSel];

    // Synchroniser; first stage feeds only the second
    always_ff @(posedge clk) begin
        if (!nrst) begin
            sync1_reg <= '0;
            sync2_reg <= '0;
        end else begin
            sync1_reg <= pins;
            sync2_reg <= sync1_reg;
        end
    end

    // Level must differ from the filtered one for limit cycles
    for (genvar i = 0; i < NCHAN; i++) begin : g_ch
        wire differ = sync2_reg[i] ^ filt_reg[i];
        wire accept = differ && (cnt_reg[i] >= limit);
        wire hit = (accept & sync2_reg[i] & ef.edgeSel[2*i]) | (accept & ~sync2_reg[i] & ef.edgeSel[2*i+1]);
        always_ff @(posedge clk) begin
            if (!nrst) begin
                cnt_reg[i] <= 8'h00;
                filt_reg[i] <= 1'b0;
                pulse_reg[i] <= 1'b0;
            end else begin
                cnt_reg[i] <= (differ && !accept) ? cnt_reg[i] + 8'h01 : 8'h00;
                filt_reg[i] <= accept ? sync2_reg[i] : filt_reg[i];
                pulse_reg[i] <= hit;
            end
        end
    end

    assign ef.edgePulse = pulse_reg;
endmodule : edge_filter

// ==== edge_if.sv ====
/*
 Carrier between the capture core and its input edge detector.
 Assumes both ends share the core clock.
*/
`timescale 1ns/1ns
interface edge_if;
    import ect_pkg::*;
    logic [1:0] filterSel;
    logic [2*NCHAN-1:0] edgeSel;
    logic [NCHAN-1:0] edgePulse;
    modport detector(input filterSel, input edgeSel, output edgePulse);
    modport core(output filterSel, output edgeSel, input edgePulse);
endinterface : edge_if
